// ---- tb_uat_transceiver.sv ----
// self-checking bench of the asynchronous serial transceiver
`timescale 1ns/1ns
module tb_uat_transceiver;
    import uat_pkg::*;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_in;
    logic        tx_out;
    logic        tx_int_req;
    logic        rx_int_req;
    logic        line_inv;
    logic        listen;
    logic        nine_bits;
    logic [15:0] bit_clks;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          num_checks = 0;

    uat_transceiver dut_u (
        .clk        (clk),
        .nrst       (nrst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .rx_in      (rx_in),
        .tx_out     (tx_out),
        .tx_int_req (tx_int_req),
        .rx_int_req (rx_int_req)
    );

    uat_remote_node node_u (
        .clk       (clk),
        .line_inv  (line_inv),
        .listen    (listen),
        .nine_bits (nine_bits),
        .bit_clks  (bit_clks),
        .tx_line   (tx_out),
        .rx_line   (rx_in)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        complete_run();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic bit_check(input logic seen, input logic exp);
        check({31'h0000_0000, seen}, {31'h0000_0000, exp});
    endtask

    task automatic word_check(input logic [8:0] exp);
        check({23'h00_0000, node_u.got_word}, {23'h00_0000, exp});
    endtask

    // setup cycle, then access phase until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) give_up();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wait_rx_flag();
        int n;
        for (n = 0; n < 4000 && rx_int_req !== 1'b1; n++) @(posedge clk);
        if (rx_int_req !== 1'b1) give_up();
    endtask

    task automatic wait_frames(input int cnt);
        int n;
        for (n = 0; n < 9000 && node_u.got_count < cnt; n++) @(posedge clk);
        if (node_u.got_count < cnt) give_up();
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 300; n++) begin
            apb(1'b0, UAT_TX_STAT_OFS, 32'h0000_0000);
            if (rd[UAT_SHIFT_REGISTER_EMPTY_BIT] === 1'b1) break;
        end
        if (rd[UAT_SHIFT_REGISTER_EMPTY_BIT] !== 1'b1) give_up();
    endtask

    task automatic t_reset_map();
        rchk(UAT_RX_STAT_OFS, 32'h0000_0000);
        rchk(UAT_TX_STAT_OFS, 32'h0000_0002);
        rchk(UAT_IRQ_OFS, 32'h0000_0001);
        wr(UAT_IRQ_OFS, 32'h0000_0000);
        wr(UAT_TX_STAT_OFS, 32'h0000_0000);
        rchk(UAT_IRQ_OFS, 32'h0000_0001);
        rchk(UAT_TX_STAT_OFS, 32'h0000_0002);
        rchk(8'h20, 32'h0000_0000);
        bit_check(err, 1'b1);
        wr(8'h02, 32'h0000_00FF);
        bit_check(err, 1'b1);
        bit_check(tx_out, 1'b1);
    endtask

    // auto-baud stays clear around every buffer write
    task automatic t_tx_enable();
        wr(UAT_TX_STAT_OFS, 32'h0000_0004);
        wr(UAT_TX_DATA_OFS, 32'h0000_003C);
        wr(UAT_IRQ_OFS, 32'h0000_0010);
        repeat (40) @(posedge clk);
        bit_check(tx_out, 1'b1);
        bit_check(tx_int_req, 1'b0);
        wr(UAT_TX_STAT_OFS, 32'h0000_0034);
        #1;
        bit_check(tx_int_req, 1'b1);
        wr(UAT_RX_STAT_OFS, 32'h0000_0080);
        repeat (40) @(posedge clk);
        bit_check(tx_out, 1'b1);
        check(32'(node_u.got_count), 32'h0000_0000);
        wr(UAT_TX_STAT_OFS, 32'h0000_0024);
        wait_frames(1);
        word_check(9'h03C);
    endtask

    task automatic t_tx_back();
        wait_idle();
        wr(UAT_TX_DATA_OFS, 32'h0000_00A5);
        wr(UAT_TX_DATA_OFS, 32'h0000_005A);
        #1;
        bit_check(tx_int_req, 1'b1);
        @(posedge clk);
        #1;
        bit_check(tx_int_req, 1'b0);
        rchk(UAT_TX_STAT_OFS, 32'h0000_0024);
        wait_frames(3);
        word_check(9'h05A);
        check(32'(node_u.start_last - node_u.start_prev),
              32'h0000_00A0);
        bit_check(tx_int_req, 1'b1);
        wait_idle();
        rchk(UAT_TX_STAT_OFS, 32'h0000_0026);
        nine_bits <= 1'b1;
        wr(UAT_TX_STAT_OFS, 32'h0000_0065);
        wr(UAT_TX_DATA_OFS, 32'h0000_000F);
        wait_frames(4);
        word_check(9'h10F);
        wait_idle();
        nine_bits <= 1'b0;
        wr(UAT_TX_STAT_OFS, 32'h0000_0024);
    endtask

    task automatic t_polarity();
        listen <= 1'b0;
        wr(UAT_BAUD_OFS, 32'h0000_0030);
        line_inv <= 1'b1;
        repeat (4) @(posedge clk);
        bit_check(tx_out, 1'b0);
        listen <= 1'b1;
        wr(UAT_TX_DATA_OFS, 32'h0000_0081);
        wait_frames(5);
        word_check(9'h081);
        wr(UAT_IRQ_OFS, 32'h0000_0020);
        wr(UAT_RX_STAT_OFS, 32'h0000_0090);
        node_u.send_frame(9'h0C3, 1'b1);
        wait_rx_flag();
        rchk(UAT_RX_DATA_OFS, 32'h0000_00C3);
        wr(UAT_RX_STAT_OFS, 32'h0000_0080);
        listen <= 1'b0;
        wr(UAT_BAUD_OFS, 32'h0000_0000);
        line_inv <= 1'b0;
        repeat (4) @(posedge clk);
        listen <= 1'b1;
    endtask

    // global and peripheral enables live outside the block
    task automatic t_rx();
        nine_bits <= 1'b1;
        node_u.send_frame(9'h055, 1'b1);
        bit_check(rx_int_req, 1'b0);
        rchk(UAT_IRQ_OFS, 32'h0000_0021);
        wr(UAT_RX_STAT_OFS, 32'h0000_00D0);
        node_u.send_frame(9'h1A6, 1'b1);
        wait_rx_flag();
        wr(UAT_IRQ_OFS, 32'h0000_0000);
        rchk(UAT_IRQ_OFS, 32'h0000_0003);
        bit_check(rx_int_req, 1'b0);
        rchk(UAT_RX_STAT_OFS, 32'h0000_00D1);
        rchk(UAT_RX_DATA_OFS, 32'h0000_00A6);
        rchk(UAT_IRQ_OFS, 32'h0000_0001);
        nine_bits <= 1'b0;
        wr(UAT_RX_STAT_OFS, 32'h0000_0090);
    endtask

    task automatic t_rx_err();
        wr(UAT_IRQ_OFS, 32'h0000_0020);
        node_u.send_frame(9'h033, 1'b0);
        wait_rx_flag();
        rchk(UAT_RX_STAT_OFS, 32'h0000_0094);
        rchk(UAT_RX_DATA_OFS, 32'h0000_0033);
        node_u.send_frame(9'h011, 1'b1);
        node_u.send_frame(9'h022, 1'b1);
        rchk(UAT_RX_STAT_OFS, 32'h0000_0092);
        rchk(UAT_RX_DATA_OFS, 32'h0000_0011);
        wr(UAT_RX_STAT_OFS, 32'h0000_0080);
        rchk(UAT_RX_STAT_OFS, 32'h0000_0080);
        wr(UAT_RX_STAT_OFS, 32'h0000_0090);
        node_u.send_frame(9'h044, 1'b1);
        wait_rx_flag();
        rchk(UAT_RX_DATA_OFS, 32'h0000_0044);
    endtask

    task automatic t_rates();
        wr(UAT_TX_STAT_OFS, 32'h0000_0020);
        bit_clks <= 16'h0040;
        wr(UAT_TX_DATA_OFS, 32'h0000_0096);
        wait_frames(6);
        word_check(9'h096);
        wait_idle();
        wr(UAT_BAUD_OFS, 32'h0000_0008);
        wr(UAT_DIV_LO_OFS, 32'h0000_0001);
        bit_clks <= 16'h0020;
        wr(UAT_TX_DATA_OFS, 32'h0000_0069);
        wait_frames(7);
        word_check(9'h069);
    endtask

    initial begin
        nrst      = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0000_0000;
        line_inv  = 1'b0;
        listen    = 1'b1;
        nine_bits = 1'b0;
        bit_clks  = 16'h0010;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset_map();
        t_tx_enable();
        t_tx_back();
        t_polarity();
        t_rx();
        t_rx_err();
        t_rates();
        complete_run();
    end
endmodule

// ---- uat_pkg.sv ----
// register map, field positions and reset values of the serial transceiver
package uat_pkg;
    localparam logic [7:0] UAT_RX_STAT_OFS  = 8'h00;
    localparam logic [7:0] UAT_TX_DATA_OFS  = 8'h04;
    localparam logic [7:0] UAT_TX_STAT_OFS  = 8'h08;
    localparam logic [7:0] UAT_BAUD_OFS     = 8'h0C;
    localparam logic [7:0] UAT_DIV_HI_OFS   = 8'h10;
    localparam logic [7:0] UAT_DIV_LO_OFS   = 8'h14;
    localparam logic [7:0] UAT_RX_DATA_OFS  = 8'h18;
    localparam logic [7:0] UAT_IRQ_OFS      = 8'h1C;
    // receive_status_control
    localparam int UAT_SERIAL_PORT_ENABLE_BIT  = 7;
    localparam int UAT_RX9_BIT   = 6;
    localparam int UAT_CONTINUOUS_RECEIVE_ENABLE_BIT  = 4;
    localparam int UAT_FRAMING_ERROR_FLAG_BIT  = 2;
    localparam int UAT_OVERRUN_ERROR_FLAG_BIT  = 1;
    localparam int UAT_RECEIVED_NINTH_BIT_BIT  = 0;
    // transmit_status_control
    localparam int UAT_TX9_BIT   = 6;
    localparam int UAT_TRANSMITTER_ENABLE_BIT  = 5;
    localparam int UAT_SYNC_BIT  = 4;
    localparam int UAT_HIGH_SPEED_RATE_SELECT_BIT  = 2;
    localparam int UAT_SHIFT_REGISTER_EMPTY_BIT  = 1;
    localparam int UAT_TRANSMIT_NINTH_BIT_BIT  = 0;
    // baud_control
    localparam int UAT_RXINV_BIT = 5;
    localparam int UAT_TXINV_BIT = 4;
    localparam int UAT_WIDE_BIT  = 3;
    localparam int UAT_ABD_BIT   = 0;
    // flag and interrupt enable register
    localparam int UAT_RCIE_BIT  = 5;
    localparam int UAT_TXIE_BIT  = 4;
    localparam int UAT_RCIF_BIT  = 1;
    localparam int UAT_TXIF_BIT  = 0;
    // cycle and bit counts, default read byte
    localparam logic [3:0] UAT_SAMPLES_LAST = 4'hF;
    localparam logic [3:0] UAT_MID_SAMPLE   = 4'h7;
    localparam logic [1:0] UAT_QUARTER_LAST = 2'h3;
    localparam logic [3:0] UAT_LAST_BIT_8   = 4'h7;
    localparam logic [3:0] UAT_LAST_BIT_9   = 4'h8;
    localparam logic [7:0] UAT_BYTE_RESET   = 8'h00;

    typedef enum logic [1:0] {
        UAT_IDLE  = 2'b00,
        UAT_START = 2'b01,
        UAT_DATA  = 2'b11,
        UAT_STOP  = 2'b10
    } uat_phase_type;
endpackage

// ---- uat_remote_node.sv ----
// remote serial node: drives the receive line, decodes the transmit line
`timescale 1ns/1ns
module uat_remote_node (
    input  wire logic        clk,
    input  wire logic        line_inv,
    input  wire logic        listen,
    input  wire logic        nine_bits,
    input  wire logic [15:0] bit_clks,
    input  wire logic        tx_line,
    output logic             rx_line
);
    logic       level = 1'b1;
    logic       line_now;
    logic [8:0] got_word = 9'h000;
    int         got_count = 0;
    int         cyc = 0;
    int         start_prev = 0;
    int         start_last = 0;

    // idle level is the stop level, inverted with the line
    assign rx_line  = level ^ line_inv;
    assign line_now = tx_line ^ line_inv;

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // one line bit held for a whole bit time
    task automatic drive_bit(input logic b);
        level <= b;
        repeat (bit_clks) @(posedge clk);
    endtask

    // start, data lsb first, stop, no parity
    task automatic send_frame(input logic [8:0] word, input logic stop_ok);
        drive_bit(1'b0);
        for (int i = 0; i < (nine_bits ? 9 : 8); i++) begin
            drive_bit(word[i]);
        end
        drive_bit(stop_ok);
        drive_bit(1'b1);
    endtask

    // mid-bit decoder of the transmit line
    initial begin : decode
        logic [8:0] w;
        forever begin
            @(posedge clk);
            if (listen && line_now === 1'b0) begin
                start_prev = start_last;
                start_last = cyc;
                w = 9'h000;
                repeat (bit_clks / 2) @(posedge clk);
                for (int i = 0; i < (nine_bits ? 9 : 8); i++) begin
                    repeat (bit_clks) @(posedge clk);
                    w[i] = line_now;
                end
                repeat (bit_clks) @(posedge clk);
                got_word = w;
                got_count++;
            end
        end
    end
endmodule

// ---- uat_transceiver.sv ----
// asynchronous serial transceiver with apb register access
// How it works
// - async operation only while the synchronous-select bit is clear
// - frame is start bit, eight or nine data bits, one stop bit
// - both directions shift lsb first at a shared rate; tx9 and rx9 set each data width
// - rate generator ticks at x16 or x64 the bit rate
// - no parity logic; a ninth bit can carry software parity
// - polarity bits invert the transmit and receive lines
// - shift register reloads at idle or after the stop bit, at once if full
// - buffer-empty flag ignores its enable and software cannot clear it
// - buffer-empty flag drops only in the second cycle after a write
// - shift-register-empty status bit, no interrupt attached
// - setting transmitter enable also sets the buffer-empty flag
// - ninth transmit bit is sent as ninth data bit
// - writing the holding buffer starts transmission when enabled
// - receiver samples the line at x16 the bit rate
// - reception needs port enable and continuous receive enable
// - completed character sets flag; interrupt only if enabled
// - ninth bit and errors in status, data in receive buffer
// - clearing continuous receive enable clears pending errors
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
module uat_transceiver
    import uat_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_int_req,
    output logic             rx_int_req
);
    typedef struct packed {
        logic          serial_port_enable;
        logic          rx9;
        logic          continuous_receive_enable;
        logic          tx9;
        logic          transmitter_enable;
        logic          sync;
        logic          high_speed_rate_select;
        logic          transmit_ninth_bit;
        logic          rxinv;
        logic          txinv;
        logic          wide;
        logic          abd;
        logic [7:0]    div_hi;
        logic [7:0]    div_lo;
        logic          txie;
        logic          rcie;
        logic [7:0]    thr;
        logic          thr_full;
        logic          txif;
        logic [15:0]   brg_cnt;
        logic [1:0]    quarter;
        uat_phase_type tx_state;
        logic [8:0]    tx_sr;
        logic [3:0]    tx_bit;
        logic [3:0]    tx_cnt;
        logic          tx_space;
        uat_phase_type rx_state;
        logic [8:0]    rx_sr;
        logic [3:0]    rx_bit;
        logic [3:0]    rx_cnt;
        logic [7:0]    rx_data;
        logic          received_ninth_bit;
        logic          framing_error_flag;
        logic          overrun_error_flag;
        logic          rcif;
    } uat_state_type;

    uat_state_type s_reg;
    uat_state_type s_next;
    logic          access;
    logic          wr;
    logic          rd_rx;
    logic          mapped;
    logic          tick;
    logic          samp;
    logic          tx_on;
    logic          rx_on;
    logic          tx_load;
    logic          rx_done;
    logic          rxv;
    logic          transmitter_enable_rise;
    logic [15:0]   divisor;
    logic [7:0]    rbyte;

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign rd_rx  = access && !pwrite && paddr == UAT_RX_DATA_OFS;
    assign mapped = paddr[1:0] == 2'b00 && paddr <= UAT_IRQ_OFS;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    assign divisor = s_reg.wide ? {s_reg.div_hi, s_reg.div_lo}
                                : {8'h00, s_reg.div_lo};
    // generator frozen while auto-baud owns it
    assign tick = s_reg.serial_port_enable && !s_reg.abd && s_reg.brg_cnt == 16'h0000;
    // x64 mode only when both rate bits clear; divided to x16 samples
    assign samp = tick && (s_reg.high_speed_rate_select || s_reg.wide ||
                           s_reg.quarter == UAT_QUARTER_LAST);
    assign tx_on = s_reg.serial_port_enable && s_reg.transmitter_enable && !s_reg.sync;
    assign rx_on = s_reg.serial_port_enable && s_reg.continuous_receive_enable && !s_reg.sync &&
                   !s_reg.abd && !s_reg.overrun_error_flag;
    assign rxv = rx_in ^ s_reg.rxinv;
    assign transmitter_enable_rise = wr && paddr == UAT_TX_STAT_OFS &&
                       pwdata[UAT_TRANSMITTER_ENABLE_BIT] && !s_reg.transmitter_enable;
    // reload at idle or right after the stop bit's last sample
    assign tx_load = tx_on && s_reg.thr_full &&
                     (s_reg.tx_state == UAT_IDLE ||
                      (s_reg.tx_state == UAT_STOP && samp &&
                       s_reg.tx_cnt == UAT_SAMPLES_LAST));
    assign rx_done = rx_on && s_reg.rx_state == UAT_STOP && samp &&
                     s_reg.rx_cnt == UAT_SAMPLES_LAST;

    always_comb begin
        s_next = s_reg;
        if (wr) begin
            unique case (paddr)
                UAT_RX_STAT_OFS: begin
                    s_next.serial_port_enable = pwdata[UAT_SERIAL_PORT_ENABLE_BIT];
                    s_next.rx9  = pwdata[UAT_RX9_BIT];
                    s_next.continuous_receive_enable = pwdata[UAT_CONTINUOUS_RECEIVE_ENABLE_BIT];
                end
                UAT_TX_DATA_OFS: begin
                    s_next.thr      = pwdata[7:0];
                    s_next.thr_full = 1'b1;
                end
                UAT_TX_STAT_OFS: begin
                    s_next.tx9  = pwdata[UAT_TX9_BIT];
                    s_next.transmitter_enable = pwdata[UAT_TRANSMITTER_ENABLE_BIT];
                    s_next.sync = pwdata[UAT_SYNC_BIT];
                    s_next.high_speed_rate_select = pwdata[UAT_HIGH_SPEED_RATE_SELECT_BIT];
                    s_next.transmit_ninth_bit = pwdata[UAT_TRANSMIT_NINTH_BIT_BIT];
                end
                UAT_BAUD_OFS: begin
                    s_next.rxinv = pwdata[UAT_RXINV_BIT];
                    s_next.txinv = pwdata[UAT_TXINV_BIT];
                    s_next.wide  = pwdata[UAT_WIDE_BIT];
                    s_next.abd   = pwdata[UAT_ABD_BIT];
                end
                UAT_DIV_HI_OFS: s_next.div_hi = pwdata[7:0];
                UAT_DIV_LO_OFS: s_next.div_lo = pwdata[7:0];
                UAT_IRQ_OFS: begin
                    s_next.txie = pwdata[UAT_TXIE_BIT];
                    s_next.rcie = pwdata[UAT_RCIE_BIT];
                end
                default: ;
            endcase
        end
        // rate generator
        if (!s_reg.serial_port_enable || s_reg.abd) begin
            s_next.brg_cnt = divisor;
            s_next.quarter = 2'b00;
        end else if (tick) begin
            s_next.brg_cnt = divisor;
            s_next.quarter = s_reg.quarter + 2'b01;
        end else begin
            s_next.brg_cnt = s_reg.brg_cnt - 16'h0001;
        end
        // transmitter, 16 samples per bit
        if (samp && s_reg.tx_state != UAT_IDLE) begin
            s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
        end
        unique case (s_reg.tx_state)
            UAT_IDLE: ;
            UAT_START: begin
                if (samp && s_reg.tx_cnt == UAT_SAMPLES_LAST) begin
                    s_next.tx_state = UAT_DATA;
                    s_next.tx_bit   = 4'h0;
                end
            end
            UAT_DATA: begin
                if (samp && s_reg.tx_cnt == UAT_SAMPLES_LAST) begin
                    s_next.tx_sr  = {1'b0, s_reg.tx_sr[8:1]};
                    s_next.tx_bit = s_reg.tx_bit + 4'h1;
                    if (s_reg.tx_bit == (s_reg.tx9 ? UAT_LAST_BIT_9
                                                   : UAT_LAST_BIT_8)) begin
                        s_next.tx_state = UAT_STOP;
                    end
                end
            end
            UAT_STOP: begin
                if (samp && s_reg.tx_cnt == UAT_SAMPLES_LAST) begin
                    s_next.tx_state = UAT_IDLE;
                end
            end
        endcase
        if (!tx_on) begin
            s_next.tx_state = UAT_IDLE;
        end
        if (tx_load) begin
            // ninth bit sits above the byte; ignored when 8-bit
            s_next.tx_sr    = {s_reg.transmit_ninth_bit, s_reg.thr};
            s_next.tx_state = UAT_START;
            s_next.tx_cnt   = 4'h0;
            // a buffer write in the same cycle keeps the buffer full
            s_next.thr_full = wr && paddr == UAT_TX_DATA_OFS;
        end
        s_next.tx_space = s_next.tx_state == UAT_START ||
                          (s_next.tx_state == UAT_DATA &&
                           !s_next.tx_sr[0]);
        // flag follows buffer with one cycle lag
        s_next.txif = !s_reg.thr_full || transmitter_enable_rise;
        // receiver, x16 sampling, middle sample decides
        if (samp && s_reg.rx_state != UAT_IDLE) begin
            s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
        end
        unique case (s_reg.rx_state)
            UAT_IDLE: begin
                if (samp && !rxv) begin
                    s_next.rx_state = UAT_START;
                    s_next.rx_cnt   = 4'h0;
                end
            end
            UAT_START: begin
                if (samp && s_reg.rx_cnt == UAT_MID_SAMPLE) begin
                    s_next.rx_state = rxv ? UAT_IDLE : UAT_DATA;
                    s_next.rx_cnt   = 4'h0;
                    s_next.rx_bit   = 4'h0;
                    s_next.rx_sr    = 9'h000;
                end
            end
            UAT_DATA: begin
                if (samp && s_reg.rx_cnt == UAT_SAMPLES_LAST) begin
                    s_next.rx_sr[s_reg.rx_bit] = rxv;
                    s_next.rx_bit = s_reg.rx_bit + 4'h1;
                    if (s_reg.rx_bit == (s_reg.rx9 ? UAT_LAST_BIT_9
                                                   : UAT_LAST_BIT_8)) begin
                        s_next.rx_state = UAT_STOP;
                    end
                end
            end
            UAT_STOP: begin
                if (rx_done) begin
                    s_next.rx_state = UAT_IDLE;
                end
            end
        endcase
        if (!rx_on) begin
            s_next.rx_state = UAT_IDLE;
        end
        if (rd_rx) begin
            s_next.rcif = 1'b0;
        end
        if (rx_done) begin
            if (s_reg.rcif && !rd_rx) begin
                s_next.overrun_error_flag = 1'b1;
            end else begin
                s_next.rx_data = s_reg.rx_sr[7:0];
                s_next.received_ninth_bit    = s_reg.rx_sr[8];
                s_next.framing_error_flag    = !rxv;
                s_next.rcif    = 1'b1;
            end
        end
        if (!s_next.continuous_receive_enable) begin
            s_next.overrun_error_flag = 1'b0;
            s_next.framing_error_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        unique case (paddr)
            UAT_RX_STAT_OFS: rbyte = {s_reg.serial_port_enable, s_reg.rx9, 1'b0,
                                      s_reg.continuous_receive_enable, 1'b0, s_reg.framing_error_flag,
                                      s_reg.overrun_error_flag, s_reg.received_ninth_bit};
            UAT_TX_DATA_OFS: rbyte = s_reg.thr;
            UAT_TX_STAT_OFS: rbyte = {1'b0, s_reg.tx9, s_reg.transmitter_enable,
                                      s_reg.sync, 1'b0, s_reg.high_speed_rate_select,
                                      s_reg.tx_state == UAT_IDLE,
                                      s_reg.transmit_ninth_bit};
            UAT_BAUD_OFS:    rbyte = {2'b00, s_reg.rxinv, s_reg.txinv,
                                      s_reg.wide, 2'b00, s_reg.abd};
            UAT_DIV_HI_OFS:  rbyte = s_reg.div_hi;
            UAT_DIV_LO_OFS:  rbyte = s_reg.div_lo;
            UAT_RX_DATA_OFS: rbyte = s_reg.rx_data;
            UAT_IRQ_OFS:     rbyte = {2'b00, s_reg.rcie, s_reg.txie,
                                      2'b00, s_reg.rcif, s_reg.txif};
            default:         rbyte = UAT_BYTE_RESET;
        endcase
        prdata = {24'h00_0000, rbyte};
    end

    assign tx_out     = !(s_reg.tx_space ^ s_reg.txinv);
    assign tx_int_req = s_reg.txif && s_reg.txie;
    assign rx_int_req = s_reg.rcif && s_reg.rcie;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_flag_lag;
        wr && paddr == UAT_TX_DATA_OFS && s_reg.txif && !transmitter_enable_rise
            |=> s_reg.txif;
    endproperty
    a_flag_lag: assert property (p_flag_lag)
        else $error("buffer-empty flag cleared too early");

    property p_reload_point;
        $fell(s_reg.thr_full) |-> s_reg.tx_state == UAT_START &&
            $past(s_reg.tx_state) inside {UAT_IDLE, UAT_STOP};
    endproperty
    a_reload_point: assert property (p_reload_point)
        else $error("shift register loaded mid-frame");

    property p_idle_level;
        s_reg.tx_state == UAT_IDLE |-> tx_out == !s_reg.txinv;
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("transmit line not at stop level while idle");

    property p_start_bit;
        $rose(s_reg.tx_state == UAT_START) |-> tx_out == s_reg.txinv;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit has wrong level");

    property p_write_starts;
        wr && paddr == UAT_TX_DATA_OFS && tx_on &&
        s_reg.tx_state == UAT_IDLE && !s_reg.thr_full
            |-> ##2 s_reg.tx_state == UAT_START;
    endproperty
    a_write_starts: assert property (p_write_starts)
        else $error("write did not start a frame");

    property p_rx_flag;
        rx_done |=> s_reg.rcif || s_reg.overrun_error_flag || !s_reg.continuous_receive_enable;
    endproperty
    a_rx_flag: assert property (p_rx_flag)
        else $error("completed character not flagged");

    property p_rx_gate;
        !(s_reg.serial_port_enable && s_reg.continuous_receive_enable) |=> s_reg.rx_state == UAT_IDLE;
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("receiver ran while disabled");

    property p_err_clear;
        !s_reg.continuous_receive_enable ##1 !s_reg.continuous_receive_enable |-> !s_reg.overrun_error_flag && !s_reg.framing_error_flag;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error survived receive disable");

    property p_flag_sticks;
        !s_reg.thr_full ##1 !s_reg.thr_full |-> s_reg.txif;
    endproperty
    a_flag_sticks: assert property (p_flag_sticks)
        else $error("buffer-empty flag low while buffer empty");

    c_back_to_back: cover property (tx_load &&
                                    s_reg.tx_state == UAT_STOP);
    c_rx_frame: cover property (rx_done && !s_reg.rcif);
    c_overrun: cover property ($rose(s_reg.overrun_error_flag));
    c_framing: cover property ($rose(s_reg.framing_error_flag));
endmodule
